//--- include/dcc_pkg.sv
// Package of register map, field layout and mode codes for the dual comparator control.
package dcc_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [7:0] DCC_IDX_PORT_DATA = 8'h05;
  localparam logic [7:0] DCC_IDX_INT_CTRL = 8'h0b;
  localparam logic [7:0] DCC_IDX_PIR = 8'h0c;
  localparam logic [7:0] DCC_IDX_CMP_CTRL = 8'h1f;
  localparam logic [7:0] DCC_IDX_PORT_DIR = 8'h85;
  localparam logic [7:0] DCC_IDX_PIE = 8'h8c;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int DCC_BIT_SECOND_RESULT = 7;
  localparam int DCC_BIT_FIRST_RESULT = 6;
  localparam int DCC_BIT_INPUT_SWITCH = 3;
  localparam int DCC_BIT_CHANGE_FLAG = 6;
  localparam int DCC_BIT_CHANGE_ENABLE = 6;
  localparam int DCC_BIT_GLOBAL_EN = 7;
  localparam int DCC_BIT_PERIPH_EN = 6;
  localparam int DCC_PIN_FIRST_RESULT = 3;
  localparam int DCC_PIN_SECOND_RESULT = 4;
  localparam int DCC_PORT_W = 5;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [7:0] DCC_RST_INT_CTRL = 8'h00;
  localparam logic [4:0] DCC_RST_PORT_DIR = 5'h1f;
  localparam logic [4:0] DCC_RST_PORT_DATA = 5'h00;
  localparam logic [31:0] DCC_RDATA_NONE = 32'h0000_0000;

  // ****************************************************************
  // Comparator modes.
  // ****************************************************************
  typedef enum logic [2:0] {
    DCC_MODE_RESET = 3'b000,
    DCC_MODE_ONE_IND = 3'b001,
    DCC_MODE_INT_REF = 3'b010,
    DCC_MODE_TWO_COMMON = 3'b011,
    DCC_MODE_TWO_IND = 3'b100,
    DCC_MODE_ONE_ONLY = 3'b101,
    DCC_MODE_PIN_OUT = 3'b110,
    DCC_MODE_OFF = 3'b111
  } dcc_mode_type;

  // Pins of the low port nibble that each mode leaves as analog inputs.
  localparam logic [3:0] DCC_ANA_RESET = 4'hf;
  localparam logic [3:0] DCC_ANA_ONE_IND = 4'hf;
  localparam logic [3:0] DCC_ANA_INT_REF = 4'hf;
  localparam logic [3:0] DCC_ANA_TWO_COMMON = 4'h7;
  localparam logic [3:0] DCC_ANA_TWO_IND = 4'hf;
  localparam logic [3:0] DCC_ANA_ONE_ONLY = 4'h3;
  localparam logic [3:0] DCC_ANA_PIN_OUT = 4'h7;
  localparam logic [3:0] DCC_ANA_OFF = 4'h0;

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic [9:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } dcc_bus_req_type;

  typedef struct packed {
    dcc_mode_type mode;
    logic input_switch;
  } dcc_cfg_type;

  typedef struct packed {
    dcc_cfg_type cfg;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] latched;
    logic change_flag;
    logic change_enable;
    logic [7:0] int_ctrl;
    logic [DCC_PORT_W-1:0] port_dir;
    logic [DCC_PORT_W-1:0] port_data;
    logic ack;
    logic [31:0] rdata;
  } dcc_state_type;

endpackage

//--- design/dcc_top.sv
// Control and status logic around the two comparators, with an Avalon-MM register slave.
//
// Function
// R01: Each result bit is high when positive input exceeds negative input, low otherwise.
// R02: Mode 010 routes the internal reference to both comparators' positive inputs.
// R03: Result bits read in control register bits 7:6 and ignore writes.
// R04: Mode 110 drives both result pins with raw, unsynchronised comparator results.
// R05: In pin output mode, direction bits still gate each result pin driver.
// R06: Port data reads return zero for pins the mode makes analog inputs.
// R07: Change flag sets when either output differs from the last latched value.
// R08: Change flag lives at bit 6 of the peripheral interrupt flags register.
// R09: Writing zero clears the change flag; writing one sets it.
// R10: Request reaches the core only with change, peripheral and global enables set.
// R11: Change flag still sets while any enable bit is clear.
// R12: A change during a control register read may be missed; optional quirk.
// R13: Any control register read or write latches current outputs, ending mismatch.
// R14: Flag keeps setting while a mismatch persists; clearing sticks only after access.
// R15: Software initialises pins, mode, direction, waits 10us, then clears and enables.
// R16: Software waits the response time after a new reference or input.
// R17: In sleep an active comparator works and an enabled change interrupt wakes.
// R18: Mode 111 powers down both comparators.
// R19: Waking from sleep leaves the control register unchanged.
// R20: Reset forces control register to mode 000, all comparator pins analog.
// R21: Comparators stay powered down for the whole reset interval.
// R22: Software disables change interrupts while changing the mode field.
// R23: Both results are synchronised to the clock before mismatch comparison.
// R24: Interrupt request is the AND of flag, change, peripheral and global enables.
`timescale 1ns/1ps
`default_nettype none

module dcc_top
  import dcc_pkg::*;
#(
  parameter int PORT_W = DCC_PORT_W
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic first_cmp_raw_in,
  input wire logic second_cmp_raw_in,
  input wire logic sleep_in,
  input wire logic [PORT_W-1:0] port_pin_in,
  output logic [PORT_W-1:0] port_pin_out,
  output logic [PORT_W-1:0] port_pin_oe_out,
  output logic [2:0] comparator_mode_field_out,
  output logic input_switch_bit_out,
  output logic int_ref_to_positive_out,
  output logic comparators_power_down_out,
  output logic irq_out,
  output logic wake_out
);

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  function automatic logic [3:0] analog_mask(input dcc_mode_type m);
    logic [3:0] r;
    r = DCC_ANA_RESET;
    case (m)
      DCC_MODE_RESET: r = DCC_ANA_RESET;
      DCC_MODE_ONE_IND: r = DCC_ANA_ONE_IND;
      DCC_MODE_INT_REF: r = DCC_ANA_INT_REF;
      DCC_MODE_TWO_COMMON: r = DCC_ANA_TWO_COMMON;
      DCC_MODE_TWO_IND: r = DCC_ANA_TWO_IND;
      DCC_MODE_ONE_ONLY: r = DCC_ANA_ONE_ONLY;
      DCC_MODE_PIN_OUT: r = DCC_ANA_PIN_OUT;
      DCC_MODE_OFF: r = DCC_ANA_OFF;
      default: r = DCC_ANA_RESET;
    endcase
    return r;
  endfunction

  function automatic logic idx_hit(input logic [9:0] addr, input logic [7:0] idx);
    return addr[9:2] == idx;
  endfunction

  dcc_bus_req_type req;
  dcc_state_type st_r;
  dcc_state_type st_nxt;
  logic access;
  logic done;
  logic cmp_ctrl_done;
  logic mismatch;
  logic [PORT_W-1:0] ana_full;
  logic [7:0] cmp_ctrl_view;
  logic [7:0] pir_view;
  logic [7:0] pie_view;

  assign req.address = avs_address_in;
  assign req.read = avs_read_in;
  assign req.write = avs_write_in;
  assign req.writedata = avs_writedata_in;
  assign req.byteenable = avs_byteenable_in;

  // ****************************************************************
  // Bus handshake.
  // ****************************************************************
  // Every access takes two edges: the first registers read data, the second completes it.
  assign access = req.read | req.write;
  assign done = access & st_r.ack;
  assign avs_waitrequest_out = access & ~st_r.ack;
  assign avs_readdata_out = st_r.rdata;
  assign cmp_ctrl_done = done & idx_hit(req.address, DCC_IDX_CMP_CTRL);

  // The synchronised results, not the first stage, feed mismatch detection.
  assign mismatch = st_r.sync2 != st_r.latched; // [R07] [R23]

  always_comb begin
    ana_full = '0;
    ana_full[3:0] = analog_mask(st_r.cfg.mode);
  end

  always_comb begin
    cmp_ctrl_view = 8'h00;
    cmp_ctrl_view[DCC_BIT_SECOND_RESULT] = st_r.sync2[1]; // [R03]
    cmp_ctrl_view[DCC_BIT_FIRST_RESULT] = st_r.sync2[0]; // [R03]
    cmp_ctrl_view[DCC_BIT_INPUT_SWITCH] = st_r.cfg.input_switch;
    cmp_ctrl_view[2:0] = st_r.cfg.mode;
    pir_view = 8'h00;
    pir_view[DCC_BIT_CHANGE_FLAG] = st_r.change_flag; // [R08]
    pie_view = 8'h00;
    pie_view[DCC_BIT_CHANGE_ENABLE] = st_r.change_enable;
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = access & ~st_r.ack;
    // The comparator decision bit is high exactly when positive exceeds negative.
    st_nxt.sync1 = {second_cmp_raw_in, first_cmp_raw_in}; // [R01] [R23]
    st_nxt.sync2 = st_r.sync1; // [R23]

    // Read data is captured on the first edge so it stands at the completing edge.
    st_nxt.rdata = DCC_RDATA_NONE;
    if (req.read & ~st_r.ack) begin
      if (idx_hit(req.address, DCC_IDX_CMP_CTRL)) begin
        st_nxt.rdata[7:0] = cmp_ctrl_view;
      end else if (idx_hit(req.address, DCC_IDX_PIR)) begin
        st_nxt.rdata[7:0] = pir_view;
      end else if (idx_hit(req.address, DCC_IDX_PIE)) begin
        st_nxt.rdata[7:0] = pie_view;
      end else if (idx_hit(req.address, DCC_IDX_INT_CTRL)) begin
        st_nxt.rdata[7:0] = st_r.int_ctrl;
      end else if (idx_hit(req.address, DCC_IDX_PORT_DIR)) begin
        st_nxt.rdata[PORT_W-1:0] = st_r.port_dir;
      end else if (idx_hit(req.address, DCC_IDX_PORT_DATA)) begin
        st_nxt.rdata[PORT_W-1:0] = port_pin_in & ~ana_full; // [R06]
      end
    end

    // Writes take effect on the completing edge; result bits are never written.
    if (done & req.write & req.byteenable[0]) begin
      if (idx_hit(req.address, DCC_IDX_CMP_CTRL)) begin
        st_nxt.cfg.mode = dcc_mode_type'(req.writedata[2:0]); // [R03]
        st_nxt.cfg.input_switch = req.writedata[DCC_BIT_INPUT_SWITCH];
      end else if (idx_hit(req.address, DCC_IDX_PIR)) begin
        st_nxt.change_flag = req.writedata[DCC_BIT_CHANGE_FLAG]; // [R09]
      end else if (idx_hit(req.address, DCC_IDX_PIE)) begin
        st_nxt.change_enable = req.writedata[DCC_BIT_CHANGE_ENABLE];
      end else if (idx_hit(req.address, DCC_IDX_INT_CTRL)) begin
        st_nxt.int_ctrl = req.writedata[7:0];
      end else if (idx_hit(req.address, DCC_IDX_PORT_DIR)) begin
        st_nxt.port_dir = req.writedata[PORT_W-1:0];
      end else if (idx_hit(req.address, DCC_IDX_PORT_DATA)) begin
        st_nxt.port_data = req.writedata[PORT_W-1:0];
      end
    end

    // Any completed control register access snapshots the current results.
    // Latching at the completing edge still lets the same edge's mismatch set the flag.
    if (cmp_ctrl_done) begin
      st_nxt.latched = st_r.sync2; // [R12] [R13]
    end

    // A standing mismatch sets the flag regardless of enables, and beats a clear.
    if (mismatch) begin
      st_nxt.change_flag = 1'b1; // [R07] [R11] [R14]
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // Sleep is not an input here, so waking leaves the control state untouched.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_r.cfg.mode <= DCC_MODE_RESET; // [R20]
      st_r.cfg.input_switch <= 1'b0; // [R20]
      st_r.sync1 <= 2'h0;
      st_r.sync2 <= 2'h0;
      st_r.latched <= 2'h0;
      st_r.change_flag <= 1'b0;
      st_r.change_enable <= 1'b0;
      st_r.int_ctrl <= DCC_RST_INT_CTRL;
      st_r.port_dir <= DCC_RST_PORT_DIR;
      st_r.port_data <= DCC_RST_PORT_DATA;
      st_r.ack <= 1'b0;
      st_r.rdata <= DCC_RDATA_NONE;
    end else begin
      st_r <= st_nxt; // [R19]
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign comparator_mode_field_out = st_r.cfg.mode;
  assign input_switch_bit_out = st_r.cfg.input_switch;
  assign int_ref_to_positive_out = st_r.cfg.mode == DCC_MODE_INT_REF; // [R02]
  // Held down through reset combinationally, so no edge is needed to power off.
  assign comparators_power_down_out = ~rst_n_in | (st_r.cfg.mode == DCC_MODE_OFF); // [R18] [R21]

  assign irq_out = st_r.change_flag & st_r.change_enable
                   & st_r.int_ctrl[DCC_BIT_PERIPH_EN] & st_r.int_ctrl[DCC_BIT_GLOBAL_EN]; // [R10] [R24]
  // Wake needs only the change enable, as the core wakes even with global enable clear.
  assign wake_out = sleep_in & st_r.change_flag & st_r.change_enable; // [R17]

  // Result pins bypass the synchroniser on purpose: their edges are asynchronous.
  always_comb begin
    port_pin_out = st_r.port_data;
    port_pin_oe_out = ~st_r.port_dir; // [R05]
    if (st_r.cfg.mode == DCC_MODE_PIN_OUT) begin
      port_pin_out[DCC_PIN_FIRST_RESULT] = first_cmp_raw_in; // [R04]
      port_pin_out[DCC_PIN_SECOND_RESULT] = second_cmp_raw_in; // [R04]
    end
  end

endmodule

`default_nettype wire

//--- verification/dcc_cmp_model.sv
// Behavioural pair of analog comparators facing the control block.
`timescale 1ns/1ps
`default_nettype none
module dcc_cmp_model (
  input wire logic power_down_in,
  input wire logic int_ref_in,
  input wire logic [7:0] vref_in,
  input wire logic [15:0] pos_in,
  input wire logic [15:0] neg_in,
  output logic [1:0] raw_out
);
  // A powered-down comparator holds its output low, so no decision leaks out of reset.
  always_comb begin
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 2; i++) begin
      p = int_ref_in ? vref_in : pos_in[8*i +: 8];
      raw_out[i] = !power_down_in && (p > neg_in[8*i +: 8]);
    end
  end
endmodule
`default_nettype wire

//--- verification/dcc_top_monitor.sv
// Checker of pin-level relations of the dual comparator control.
`timescale 1ns/1ps
`default_nettype none
module dcc_monitor #(
  parameter int PORT_W = 5
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic first_cmp_raw_in,
  input wire logic second_cmp_raw_in,
  input wire logic sleep_in,
  input wire logic [PORT_W-1:0] port_pin_out,
  input wire logic [PORT_W-1:0] port_pin_oe_out,
  input wire logic [2:0] comparator_mode_field_out,
  input wire logic int_ref_to_positive_out,
  input wire logic comparators_power_down_out,
  input wire logic irq_out,
  input wire logic wake_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_wait_drop: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("waitrequest held too long");
  a_wait_idle: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest without request");
  a_ref_route: assert property (int_ref_to_positive_out == (comparator_mode_field_out == 3'b010))
    else $error("reference routing wrong");
  a_pin_raw: assert property (comparator_mode_field_out == 3'b110
    |-> port_pin_out[4:3] == {second_cmp_raw_in, first_cmp_raw_in}) else $error("pin mux wrong");
  a_power_off: assert property (comparator_mode_field_out == 3'b111
    |-> comparators_power_down_out) else $error("off mode not powered down");
  a_power_reset: assert property (disable iff (1'b0) !rst_n_in |-> comparators_power_down_out)
    else $error("powered during reset");
  a_mode_reset: assert property (disable iff (1'b0) !rst_n_in
    |=> comparator_mode_field_out == 3'b000 && port_pin_oe_out == '0) else $error("reset state wrong");
  a_mode_hold: assert property ($changed(comparator_mode_field_out) |-> $past(avs_write_in))
    else $error("mode changed without write");
  a_wake_sleep: assert property (wake_out |-> sleep_in) else $error("wake while awake");
  c_irq: cover property (irq_out);
  c_wake: cover property (wake_out);
  c_pin_mode: cover property (comparator_mode_field_out == 3'b110 && port_pin_oe_out[3]);
endmodule
bind dcc_top dcc_monitor #(.PORT_W(PORT_W)) i_mon (.*);
`default_nettype wire

//--- verification/dcc_top_tb.sv
// Self-checking bench of the dual comparator control.
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb;
  import dcc_pkg::*;
  localparam logic [9:0] CMP = {DCC_IDX_CMP_CTRL, 2'b00};
  localparam logic [9:0] PIR = {DCC_IDX_PIR, 2'b00};
  localparam logic [9:0] PIE = {DCC_IDX_PIE, 2'b00};
  localparam logic [9:0] INTC = {DCC_IDX_INT_CTRL, 2'b00};
  localparam logic [9:0] DIR = {DCC_IDX_PORT_DIR, 2'b00};
  localparam logic [9:0] PORT = {DCC_IDX_PORT_DATA, 2'b00};
  logic clk = 1'b0;
  logic rst_n, rd, wr, wreq, sleep, isw, iref, pdn, irq, wake;
  logic [9:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [4:0] pin_in, pin_out, pin_oe;
  logic [2:0] mode;
  logic [1:0] raw;
  logic [7:0] vref, got;
  logic [15:0] pos, neg;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  dcc_top i_dut (
    .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .first_cmp_raw_in(raw[0]),
    .second_cmp_raw_in(raw[1]), .sleep_in(sleep), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe_out(pin_oe), .comparator_mode_field_out(mode),
    .input_switch_bit_out(isw), .int_ref_to_positive_out(iref),
    .comparators_power_down_out(pdn), .irq_out(irq), .wake_out(wake)
  );
  dcc_cmp_model i_cmp (
    .power_down_in(pdn), .int_ref_in(iref), .vref_in(vref), .pos_in(pos), .neg_in(neg),
    .raw_out(raw)
  );
  initial begin
    forever #2.5 clk = ~clk;
  end
  // The ceiling is far above the hundred-odd cycles the sequence needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  // ****************************************************************
  // Bus tasks.
  // ****************************************************************
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string n, input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, e, got);
  endtask
  // ****************************************************************
  // Sequence.
  // ****************************************************************
  initial begin
    {rst_n, rd, wr, sleep, addr, wdata, pos, neg} = '0;
    be = 4'hf;
    pin_in = 5'h1f;
    vref = 8'h80;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg("cmp_ctrl", CMP, 8'h00);
    rd_reg("port_dir", DIR, 8'h1f);
    rd_reg("flags", PIR, 8'h00);
    rd_reg("enables", PIE, 8'h00);
    rd_reg("int_ctrl", INTC, 8'h00);
    rd_reg("port_analog", PORT, 8'h10);
    rd_reg("unmapped", 10'h3fc, 8'h00);
    bus(1'b1, CMP, 8'hff);
    rd_reg("cmp_off", CMP, 8'h0f);
    chk("input_switch", 8'h01, {7'h00, isw});
    rd_reg("port_off", PORT, 8'h1f);
    be <= 4'h0;
    bus(1'b1, CMP, 8'h02);
    be <= 4'hf;
    rd_reg("cmp_no_be", CMP, 8'h0f);
    bus(1'b1, CMP, 8'h02);
    repeat (3) @(posedge clk);
    rd_reg("flag_set", PIR, 8'h40);
    bus(1'b1, PIR, 8'h00);
    rd_reg("flag_sticky", PIR, 8'h40);
    rd_reg("cmp_ref", CMP, 8'hc2);
    bus(1'b1, PIR, 8'h00);
    rd_reg("flag_clear", PIR, 8'h00);
    neg <= 16'hff00;
    repeat (3) @(posedge clk);
    rd_reg("flag_second", PIR, 8'h40);
    rd_reg("cmp_second", CMP, 8'h42);
    bus(1'b1, PIR, 8'h00);
    bus(1'b1, PIE, 8'h40);
    bus(1'b1, INTC, 8'hc0);
    bus(1'b1, PIR, 8'h40);
    @(posedge clk);
    chk("irq_on", 8'h01, {7'h00, irq});
    bus(1'b1, INTC, 8'h40);
    sleep <= 1'b1;
    @(posedge clk);
    chk("irq_off", 8'h00, {7'h00, irq});
    chk("wake", 8'h01, {7'h00, wake});
    rd_reg("cmp_sleep", CMP, 8'h42);
    sleep <= 1'b0;
    bus(1'b1, DIR, 8'h07);
    bus(1'b1, CMP, 8'h06);
    pos <= 16'h0010;
    @(posedge clk);
    chk("pin_oe", 8'h18, {3'h0, pin_oe});
    chk("pin_raw", 8'h01, {6'h00, pin_out[4:3]});
    rd_reg("port_pinmode", PORT, 8'h18);
    bus(1'b1, DIR, 8'h1f);
    @(posedge clk);
    chk("pin_oe_off", 8'h00, {3'h0, pin_oe});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("power_down", 8'h01, {7'h00, pdn});
    rst_n <= 1'b1;
    rd_reg("cmp_rereset", CMP, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
